// [design/rpd_defines.svh]
// register offsets, field positions, reset values and sampling mode codes
`ifndef RPD_DEFINES_SVH
`define RPD_DEFINES_SVH
`define RPD_ADDR_CTRL_A    4'h0
`define RPD_ADDR_CTRL_B    4'h1
`define RPD_ADDR_STATUS    4'h2
`define RPD_ADDR_EXPECT    4'h3
`define RPD_ADDR_DELAY     4'h4
`define RPD_A_SWSTOP       7
`define RPD_A_SWSTART      6
`define RPD_A_TM3STOP      5
`define RPD_A_TM2START     4
`define RPD_A_ONEPIN       3
`define RPD_A_RECOUNT      2
`define RPD_A_UNMATCH      1
`define RPD_A_ENABLE       0
`define RPD_B_PERIOD_HI    7
`define RPD_B_PERIOD_LO    6
`define RPD_B_MODE_HI      5
`define RPD_B_MODE_LO      4
`define RPD_B_COUNT_HI     3
`define RPD_B_COUNT_LO     0
`define RPD_RST_CTRL_A     8'h00
`define RPD_RST_CTRL_B     8'h00
`define RPD_RST_EXPECT     3'h0
`define RPD_RST_DELAY      8'h00
`define RPD_MODE_PWM_ON    2'h0
`define RPD_MODE_CONT      2'h1
`define RPD_MODE_LOWER     2'h2
`endif

// [design/rpd_pkg.sv]
// types shared by the rotor position detector files
package rpd_pkg;
  typedef enum logic [1:0] {
    RPD_IDLE,
    RPD_SAMPLE
  } rpd_state_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rpd_bus_t;

  typedef struct packed {
    logic [2:0] pwm;
    logic [2:0] lower;
  } rpd_drive_t;
endpackage : rpd_pkg

// [design/rpd_prescaler.sv]
// sampling period divider producing a one-cycle enable pulse
`timescale 1ns/10ps
module rpd_prescaler #(
  parameter int WIDTH = 5
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic [WIDTH-1:0] last;

  // sel 0..3 gives clk/4, /8, /16, /32
  always_comb begin
    last  = WIDTH'((32'h4 << sel_i) - 32'h1);
    cnt_d = (cnt_q >= last) ? '0 : cnt_q + WIDTH'(1);
    tick_o = (cnt_q >= last);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : rpd_prescaler

// [design/rpd_detector.sv]
// rotor position detector: sampling, matching and detection event
//
// Operation
// RL1: software schedules commutation, start, failure timing
// RL2: compare sampled inputs against expected pattern
// RL3: six modes map to fixed U,V,W patterns
// RL4: ordinary mode stops sampling after detection
// RL5: timer 2 starts, timer 3 stops sampling
// RL6: unmatch mode detects change from start status
// RL7: start status snapshot readable by software
// RL8: sampling mode pwm-on, continuous, or lower-phase
// RL9: software uses common duty in pwm-on mode
// RL10: lower phase sampled after delay until off
// RL11: idle phases hold results used for matching
// RL12: sampling waits programmed delay after pwm on
// RL13: pwm-on is OR of phases; recount selectable
// RL14: detect after count consecutive qualifying samples
// RL15: recount clears count at pwm turn-off
// RL16: sampling period clock divided 4/8/16/32
// RL17: breaking sample restarts consecutive counter
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "rpd_defines.svh"
module rpd_detector #(
  parameter int DLY_W = 8
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       bus_we_i,
  input  wire logic       bus_re_i,
  input  wire logic [3:0] bus_addr_i,
  input  wire logic [7:0] bus_wdata_i,
  output logic      [7:0] bus_rdata_o,
  input  wire logic       phase_u_position_input_i,
  input  wire logic       phase_v_position_input_i,
  input  wire logic       phase_w_position_input_i,
  input  wire logic [2:0] pwm_phase_i,
  input  wire logic [2:0] lower_conduct_i,
  input  wire logic       timer2_event_i,
  input  wire logic       timer3_event_i,
  output logic            position_detect_interrupt_o,
  output logic            sampling_active_o
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pos_m_q;
  logic [2:0] pos_s_q;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pos_m_q <= 3'h0;
      pos_s_q <= 3'h0;
    end else begin
      pos_m_q <= {phase_u_position_input_i, phase_v_position_input_i,
                  phase_w_position_input_i};
      pos_s_q <= pos_m_q;
    end
  end

  rpd_pkg::rpd_drive_t drv;
  assign drv.pwm   = pwm_phase_i;
  assign drv.lower = lower_conduct_i;

  rpd_pkg::rpd_bus_t bus;
  assign bus.we    = bus_we_i;
  assign bus.re    = bus_re_i;
  assign bus.addr  = bus_addr_i;
  assign bus.wdata = bus_wdata_i;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]       ctrl_a_q, ctrl_a_d;
  logic [7:0]       ctrl_b_q, ctrl_b_d;
  logic [2:0]       expect_q, expect_d;
  logic [DLY_W-1:0] delay_q, delay_d;
  logic [7:0]       rdata_q, rdata_d;
  logic             sw_start, sw_stop;
  logic [2:0]       snap_q;
  logic             det_q;

  always_comb begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    expect_d = expect_q;
    delay_d  = delay_q;
    sw_start = 1'b0;
    sw_stop  = 1'b0;
    rdata_d  = 8'h00;
    if (bus.we) begin
      case (bus.addr)
        `RPD_ADDR_CTRL_A: begin
          // start and stop bits are one-shot commands
          ctrl_a_d = bus.wdata & 8'h3F;
          sw_start = bus.wdata[`RPD_A_SWSTART];
          sw_stop  = bus.wdata[`RPD_A_SWSTOP];
        end
        `RPD_ADDR_CTRL_B: ctrl_b_d = bus.wdata;
        `RPD_ADDR_EXPECT: expect_d = bus.wdata[2:0];
        `RPD_ADDR_DELAY:  delay_d  = DLY_W'(bus.wdata);
        default: ;
      endcase
    end
    if (bus.re) begin
      case (bus.addr)
        `RPD_ADDR_CTRL_A: rdata_d = ctrl_a_q;
        `RPD_ADDR_CTRL_B: rdata_d = ctrl_b_q;
        `RPD_ADDR_STATUS: begin
          rdata_d = {3'h0, det_q, sampling_active_o, snap_q}; // [RL7]
        end
        `RPD_ADDR_EXPECT: rdata_d = {5'h00, expect_q};
        `RPD_ADDR_DELAY:  rdata_d = 8'(delay_q);
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_a_q <= `RPD_RST_CTRL_A;
      ctrl_b_q <= `RPD_RST_CTRL_B;
      expect_q <= `RPD_RST_EXPECT;
      delay_q  <= DLY_W'(`RPD_RST_DELAY);
      rdata_q  <= 8'h00;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      expect_q <= expect_d;
      delay_q  <= delay_d;
      rdata_q  <= rdata_d;
    end
  end
  assign bus_rdata_o = rdata_q;

  logic       enable, unmatch, recount, one_pin;
  logic [1:0] smode;
  logic [3:0] need;
  assign enable  = ctrl_a_q[`RPD_A_ENABLE];
  assign unmatch = ctrl_a_q[`RPD_A_UNMATCH];
  assign recount = ctrl_a_q[`RPD_A_RECOUNT];
  assign one_pin = ctrl_a_q[`RPD_A_ONEPIN];
  assign smode   = ctrl_b_q[`RPD_B_MODE_HI:`RPD_B_MODE_LO];
  assign need    = ctrl_b_q[`RPD_B_COUNT_HI:`RPD_B_COUNT_LO];

  // ----------------------------------------------------------------
  // sampling period
  // ----------------------------------------------------------------
  logic tick;
  rpd_prescaler #(
    .WIDTH (5)
  ) u_presc (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .sel_i     (ctrl_b_q[`RPD_B_PERIOD_HI:`RPD_B_PERIOD_LO]), // [RL16]
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------
  // gating windows
  // ----------------------------------------------------------------
  logic             pwm_on, pwm_on_q;
  logic [DLY_W-1:0] pwm_dly_q, pwm_dly_d;
  logic [2:0]       low_q;
  logic [2:0]       ph_gate;
  logic [DLY_W-1:0] ph_dly_q [3];
  logic [DLY_W-1:0] ph_dly_d [3];
  logic             pwm_ok;

  assign pwm_on = |drv.pwm; // [RL13]

  always_comb begin
    // delay counts system clocks from the pwm rising edge
    if (!pwm_on) begin
      pwm_dly_d = '0;
    end else if (pwm_dly_q != delay_q) begin
      pwm_dly_d = pwm_dly_q + DLY_W'(1);
    end else begin
      pwm_dly_d = pwm_dly_q;
    end
    pwm_ok = pwm_on && (pwm_dly_q == delay_q); // [RL12]
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ph
      always_comb begin
        if (!drv.lower[gi]) begin
          ph_dly_d[gi] = '0;
        end else if (ph_dly_q[gi] != delay_q) begin
          ph_dly_d[gi] = ph_dly_q[gi] + DLY_W'(1);
        end else begin
          ph_dly_d[gi] = ph_dly_q[gi];
        end
        // window ends when the phase stops conducting
        ph_gate[gi] = drv.lower[gi] && (ph_dly_q[gi] == delay_q); // [RL10]
      end
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          ph_dly_q[gi] <= '0;
        end else begin
          ph_dly_q[gi] <= ph_dly_d[gi];
        end
      end
    end
  endgenerate

  logic [2:0] samp_en;
  always_comb begin
    case (smode) // [RL8]
      `RPD_MODE_PWM_ON: samp_en = {3{pwm_ok}};
      `RPD_MODE_CONT:   samp_en = 3'h7;
      `RPD_MODE_LOWER:  samp_en = ph_gate;
      default:          samp_en = 3'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // detection state machine
  // ----------------------------------------------------------------
  rpd_pkg::rpd_state_t st_q, st_d;
  logic [2:0] held_q, held_d;
  logic [2:0] snap_d;
  logic [3:0] cnt_q, cnt_d;
  logic       det_d, irq_d, irq_q;
  logic [2:0] view, cmp_mask;
  logic       hit, start, stop_req, stop_q, stop_d;

  always_comb begin
    // idle phases keep their last result
    view = held_q;
    for (int i = 0; i < 3; i++) begin
      if (samp_en[i] && tick) view[i] = pos_s_q[i]; // [RL11]
    end
    cmp_mask = one_pin ? 3'h4 : 3'h7;
    // bit 2 is U, bit 1 is V, bit 0 is W, H as 1 [RL3]
    hit = unmatch ? (((view ^ snap_q) & cmp_mask) != 3'h0)
                  : (((view ^ expect_q) & cmp_mask) == 3'h0); // [RL2] [RL6]
    start = enable && (sw_start ||
            (ctrl_a_q[`RPD_A_TM2START] && timer2_event_i)); // [RL5]
    stop_req = sw_stop ||
               (ctrl_a_q[`RPD_A_TM3STOP] && timer3_event_i); // [RL5]
  end

  always_comb begin
    st_d   = st_q;
    held_d = held_q;
    snap_d = snap_q;
    cnt_d  = cnt_q;
    det_d  = det_q;
    irq_d  = 1'b0;
    stop_d = stop_q | stop_req;
    case (st_q)
      rpd_pkg::RPD_IDLE: begin
        stop_d = 1'b0;
        if (start) begin
          st_d   = rpd_pkg::RPD_SAMPLE;
          snap_d = pos_s_q; // [RL6]
          held_d = pos_s_q;
          cnt_d  = 4'h0;
          det_d  = 1'b0;
        end
      end
      rpd_pkg::RPD_SAMPLE: begin
        if (!enable) begin
          st_d = rpd_pkg::RPD_IDLE;
        end else if (tick && (samp_en != 3'h0)) begin
          held_d = view;
          if (hit) begin
            if (cnt_q + 4'h1 >= need) begin // [RL14]
              irq_d = 1'b1;
              det_d = 1'b1;
              cnt_d = 4'h0;
              st_d  = rpd_pkg::RPD_IDLE; // [RL4]
            end else begin
              cnt_d = cnt_q + 4'h1;
            end
          end else begin
            cnt_d = 4'h0; // [RL17]
            // a pending stop takes effect on a sample without a match
            if (stop_q || stop_req) st_d = rpd_pkg::RPD_IDLE;
          end
        end else if (stop_q && (tick || samp_en == 3'h0)) begin
          st_d = rpd_pkg::RPD_IDLE;
        end
        if (recount && pwm_on_q && !pwm_on &&
            smode != `RPD_MODE_CONT) begin
          cnt_d = 4'h0; // [RL15]
        end
      end
      default: st_d = rpd_pkg::RPD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q      <= rpd_pkg::RPD_IDLE;
      held_q    <= 3'h0;
      snap_q    <= 3'h0;
      cnt_q     <= 4'h0;
      det_q     <= 1'b0;
      irq_q     <= 1'b0;
      stop_q    <= 1'b0;
      pwm_on_q  <= 1'b0;
      pwm_dly_q <= '0;
    end else begin
      st_q      <= st_d;
      held_q    <= held_d;
      snap_q    <= snap_d;
      cnt_q     <= cnt_d;
      det_q     <= det_d;
      irq_q     <= irq_d;
      stop_q    <= stop_d;
      pwm_on_q  <= pwm_on;
      pwm_dly_q <= pwm_dly_d;
    end
  end

  assign position_detect_interrupt_o = irq_q;
  assign sampling_active_o = (st_q == rpd_pkg::RPD_SAMPLE);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_irq_then_idle: assert property (@(posedge clk_sys_i) // [RL4]
    disable iff (rst_i) irq_q |-> !sampling_active_o && det_q)
    else $error("interrupt without ending sampling");
  a_irq_needs_samp: assert property (@(posedge clk_sys_i) // [RL14]
    disable iff (rst_i) irq_q |-> $past(sampling_active_o) && $past(tick))
    else $error("interrupt outside a sampling tick");
  a_snap_on_start: assert property (@(posedge clk_sys_i) // [RL6]
    disable iff (rst_i)
    (!sampling_active_o && start) |=> snap_q == $past(pos_s_q))
    else $error("start status not captured");
  a_start_goes: assert property (@(posedge clk_sys_i) // [RL5]
    disable iff (rst_i) (!sampling_active_o && start) |=> sampling_active_o)
    else $error("start did not begin sampling");
  a_match_irq: assert property (@(posedge clk_sys_i) // [RL2]
    disable iff (rst_i)
    (sampling_active_o && enable && tick && samp_en != 3'h0 && hit
     && !unmatch && need <= 4'h1) |=> irq_q)
    else $error("match missed");
  a_miss_clear: assert property (@(posedge clk_sys_i) // [RL17]
    disable iff (rst_i) (sampling_active_o && enable && tick &&
    samp_en != 3'h0 && !hit) |=> cnt_q == 4'h0)
    else $error("counter not restarted");
  a_dly_gate: assert property (@(posedge clk_sys_i) // [RL12]
    disable iff (rst_i) $rose(pwm_on) && delay_q != '0 |-> !pwm_ok)
    else $error("sampling during delay");
  a_pwm_or: assert property (@(posedge clk_sys_i) // [RL13]
    disable iff (rst_i)
    (smode == `RPD_MODE_PWM_ON && samp_en != 3'h0) |-> pwm_on)
    else $error("pwm-on sampling without pwm");
  a_recount_clr: assert property (@(posedge clk_sys_i) // [RL15]
    disable iff (rst_i)
    (sampling_active_o && recount && $fell(pwm_on) &&
     smode != `RPD_MODE_CONT) |=> cnt_q == 4'h0)
    else $error("recount did not clear");

  c_detect: cover property (@(posedge clk_sys_i) disable iff (rst_i) irq_q);
  c_unmatch: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    irq_q && unmatch);
  c_lower: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    irq_q && smode == `RPD_MODE_LOWER);
  c_stop: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    sampling_active_o && stop_req);
endmodule : rpd_detector

// [sim/rpd_pos_model.sv]
// behavioural position-pin source standing in for comparators or hall cells
`timescale 1ns/10ps
module rpd_pos_model (
  input  wire logic [2:0] mode_i,
  output logic            pu_o,
  output logic            pv_o,
  output logic            pw_o
);
  // ----------------------------------------------------------------------
  // pattern table
  // ----------------------------------------------------------------------
  // indices 6 and 7 give 000, a pattern no rotor position produces
  localparam logic [2:0] PAT [8] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1,
                                     3'h0, 3'h0};
  assign {pu_o, pv_o, pw_o} = PAT[mode_i];
endmodule : rpd_pos_model

// [sim/tb_rpd_detector.sv]
// self-checking bench for the rotor position detector
`timescale 1ns/10ps
module tb_rpd_detector;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  localparam logic [2:0] PAT [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  // mode time of the modelled rotor, in clocks
  localparam int         MODE_T = 16;
  logic       clk_sys_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       we        = 1'b0;
  logic       re        = 1'b0;
  logic [3:0] addr      = 4'h0;
  logic [7:0] wdata     = 8'h00;
  logic [7:0] rdata;
  logic [2:0] mode      = 3'h7;
  logic [2:0] pwm       = 3'h0;
  logic [2:0] lower     = 3'h0;
  logic       t2        = 1'b0;
  logic       t3        = 1'b0;
  logic       pu, pv, pw, irq, act;
  int         errors    = 0;
  int         checks    = 0;
  int         irq_cnt   = 0;
  int         cyc       = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  rpd_pos_model i_rpd_pos_model (.mode_i(mode), .pu_o(pu), .pv_o(pv),
                                 .pw_o(pw));
  rpd_detector i_rpd_detector (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_we_i(we), .bus_re_i(re),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
    .phase_u_position_input_i(pu), .phase_v_position_input_i(pv),
    .phase_w_position_input_i(pw), .pwm_phase_i(pwm),
    .lower_conduct_i(lower), .timer2_event_i(t2), .timer3_event_i(t3),
    .position_detect_interrupt_o(irq), .sampling_active_o(act));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // the ceiling is far above the several hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR %0t run did not finish", $time);
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    re <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic cycles(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : cycles

  // returns cycles waited; n reaches lim when no detection came
  task automatic wait_irq(input int lim, output int n);
    int c0;
    c0 = irq_cnt;
    n = 0;
    while (irq_cnt == c0 && n < lim) begin
      cycles(1);
      n++;
    end
  endtask : wait_irq

  task automatic pulse(input bit which);
    @(posedge clk_sys_i);
    if (which) t3 <= 1'b1;
    else t2 <= 1'b1;
    @(posedge clk_sys_i);
    t2 <= 1'b0;
    t3 <= 1'b0;
  endtask : pulse

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_patterns();
    logic [7:0] d;
    int n;
    for (int m = 0; m < 6; m++) begin
      mode <= 3'h7;
      wr(4'h3, {5'h00, PAT[m]});
      wr(4'h1, 8'h11);
      // start is only taken once enable already stands
      wr(4'h0, 8'h01);
      wr(4'h0, 8'h41);
      cycles(12);
      chk(act, 1'b1);
      mode <= m[2:0];
      wait_irq(20, n);
      chk(n < 20, 1'b1);
      cycles(2);
      chk(act, 1'b0);
      rd(4'h2, d);
      chk(d[4], 1'b1);
      wr(4'h0, 8'h00);
    end
    $display("test patterns done");
  endtask : t_patterns

  // three in a row needed; one match then a break must not detect
  task automatic t_count_break();
    int c0, n;
    mode <= 3'h7;
    wr(4'h3, 8'h05);
    wr(4'h1, 8'h13);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h41);
    c0 = irq_cnt;
    mode <= 3'h0;
    cycles(6);
    mode <= 3'h7;
    cycles(8);
    chk(8'(irq_cnt - c0), 8'h00);
    mode <= 3'h0;
    wait_irq(40, n);
    chk(n >= 8 && n <= 20, 1'b1);
    wr(4'h0, 8'h00);
    $display("test count break done");
  endtask : t_count_break

  task automatic t_unmatch();
    logic [7:0] d;
    int n;
    mode <= 3'h2;
    wr(4'h1, 8'h11);
    cycles(4);
    wr(4'h0, 8'h03);
    wr(4'h0, 8'h43);
    rd(4'h2, d);
    chk(d[2:0], 3'h6);
    wait_irq(40, n);
    chk(8'(n), 8'h28);
    mode <= 3'h3;
    wait_irq(20, n);
    chk(n < 20, 1'b1);
    wr(4'h0, 8'h00);
    $display("test unmatch done");
  endtask : t_unmatch

  task automatic t_timers();
    int c0;
    mode <= 3'h7;
    wr(4'h3, 8'h05);
    wr(4'h1, 8'h11);
    wr(4'h0, 8'h31);
    cycles(4);
    chk(act, 1'b0);
    // timer 2 fires three quarters of a mode time after the zero-cross
    cycles(MODE_T * 3 / 4);
    c0 = irq_cnt;
    pulse(1'b0);
    cycles(3);
    chk(act, 1'b1);
    pulse(1'b1);
    cycles(12);
    chk(act, 1'b0);
    chk(8'(irq_cnt - c0), 8'h00);
    wr(4'h0, 8'h00);
    $display("test timers done");
  endtask : t_timers

  // gated modes: nothing while off, detection no sooner than the delay
  task automatic t_gated(input logic [7:0] ctl, input logic [2:0] p,
                         input logic [2:0] l);
    int n;
    mode <= 3'h0;
    wr(4'h3, 8'h05);
    wr(4'h4, 8'h14);
    wr(4'h1, ctl);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h41);
    wait_irq(40, n);
    chk(8'(n), 8'h28);
    @(posedge clk_sys_i);
    pwm <= p;
    lower <= l;
    wait_irq(100, n);
    chk(n >= 20 && n < 100, 1'b1);
    @(posedge clk_sys_i);
    pwm <= 3'h0;
    lower <= 3'h0;
    wr(4'h0, 8'h00);
    $display("test gated done");
  endtask : t_gated

  // equal duty on all phases, 6 clocks on and 6 off per pulse
  task automatic pwm_burst(input int k);
    repeat (k) begin
      @(posedge clk_sys_i);
      pwm <= 3'h7;
      repeat (6) @(posedge clk_sys_i);
      pwm <= 3'h0;
      repeat (5) @(posedge clk_sys_i);
    end
    #1;
  endtask : pwm_burst

  // at most two samples per pulse, so only accumulation reaches three
  task automatic t_recount();
    int c0;
    mode <= 3'h0;
    wr(4'h3, 8'h05);
    wr(4'h4, 8'h00);
    wr(4'h1, 8'h03);
    wr(4'h0, 8'h05);
    wr(4'h0, 8'h45);
    c0 = irq_cnt;
    pwm_burst(6);
    chk(8'(irq_cnt - c0), 8'h00);
    chk(act, 1'b1);
    wr(4'h0, 8'h01);
    pwm_burst(4);
    chk(8'(irq_cnt - c0), 8'h01);
    wr(4'h0, 8'h00);
    $display("test recount done");
  endtask : t_recount

  // slowest period, one-pin compare, the idle mode and a software stop
  task automatic t_options();
    int n;
    mode <= 3'h7;
    wr(4'h3, 8'h05);
    wr(4'h1, 8'hD2);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h41);
    mode <= 3'h0;
    wait_irq(80, n);
    chk(n >= 36 && n <= 67, 1'b1);
    wr(4'h0, 8'h00);
    mode <= 3'h7;
    wr(4'h1, 8'h11);
    wr(4'h0, 8'h09);
    wr(4'h0, 8'h49);
    mode <= 3'h1;
    wait_irq(20, n);
    chk(n < 20, 1'b1);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h31);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h41);
    mode <= 3'h0;
    wait_irq(40, n);
    chk(8'(n), 8'h28);
    chk(act, 1'b1);
    wr(4'h0, 8'h81);
    cycles(2);
    chk(act, 1'b0);
    wr(4'h0, 8'h00);
    $display("test options done");
  endtask : t_options

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0], d);
      chk(d, 8'h00);
    end
    wr(4'h0, 8'h80);
    rd(4'h0, d);
    chk(d, 8'h00);
    $display("test reset values done");
    t_patterns();
    t_count_break();
    t_unmatch();
    t_timers();
    t_gated(8'h01, 3'h2, 3'h0);
    t_gated(8'h21, 3'h0, 3'h7);
    t_recount();
    t_options();
    results();
  end
endmodule : tb_rpd_detector
